/* srpd_core.sv */
// SDRAM command core: bursts, byte masks, clock suspend, refresh, power down
// How it works
// - Precharge ends read; data floats after latency
// - Precharge ends write; later write data ignored
// - Upper mask covers high byte, lower low
// - Read mask floats byte two cycles later
// - Write mask blocks byte same edge
// - Low clock gate ignores next edge, pauses
// - Suspended read holds current output word
// - Auto refresh uses internal row counter
// - Self refresh: internal timer, inputs ignored, float
// - Power-down change applied two cycles later
// - Idle plus gate low enters power down
// - Open row enters active power down
// - Other states: gate low suspends clock
// - Commands need gate high previous cycle
// - Auto-close bursts finish then precharge
`timescale 1ns/10ps
`default_nettype none

// Word FIFO between array read and data pins
module srpd_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp, rp, next_wp, next_rp;
	logic [AW:0] cnt, next_cnt;
	logic push, pop;
	assign in_ready = cnt != (AW+1)'(DEPTH);
	assign out_valid = cnt != '0;
	assign out_data = mem[rp];
	// Pointer and fill count update
	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wp = push ? wp + 1'b1 : wp;
		next_rp = pop ? rp + 1'b1 : rp;
		next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
		end
	end
	// Storage, no reset needed
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end
endmodule // srpd_fifo

module srpd_core
	import srpd_pkg::*;
#(
	parameter int ROW_BITS = 11,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic cke,
	input wire srpd_cmd_t cmd_pins,
	input wire logic [SRPD_ADDR_BITS-1:0] addr,
	input wire logic bank_sel,
	input wire logic upper_byte_mask,
	input wire logic lower_byte_mask,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic [1:0] dq_oe,
	output logic power_down_status,
	output logic [SRPD_REF_ROW_BITS-1:0] refresh_row,
	output logic protocol_violation
);
	localparam int IW = 1 + ROW_BITS + SRPD_COL_BITS;
	logic [15:0] mem [2**IW]; // Storage array
	logic cke_q; // Clock gate seen at last edge
	logic [1:0] dqm_d1; // Read mask seen at last enabled edge
	logic [2:1] tok; // Read latency tokens
	logic pd_d1; // Power-down delay stage
	srpd_dev_t dev, next_dev;
	logic [3:0] dev_tmr, next_dev_tmr;
	logic [10:0] self_refresh_entry_cmd_tmr, next_self_refresh_entry_cmd_tmr;
	logic [SRPD_REF_ROW_BITS-1:0] next_refresh_row;
	logic [2:0] cl, next_cl, bl, next_bl;
	logic burst_on, burst_wr, burst_ap, burst_bank;
	logic next_burst_on, next_burst_wr, next_burst_ap, next_burst_bank;
	logic [7:0] burst_col, next_burst_col;
	logic [8:0] burst_left, next_burst_left;
	srpd_bank_t bank_st [SRPD_BANKS];
	logic [ROW_BITS-1:0] bank_row [SRPD_BANKS];
	logic [1:0] go_act, go_pre, go_wrec;
	logic sel, illegal, ok, intr, start, all_idle, quiet, full, can;
	logic step_rd, step_wr, pop, in_pd;
	logic [2:0] op;
	logic [7:0] msk, c_col, s_col;
	logic [8:0] len, c_left;
	logic c_b, c_wr, c_ap;
	logic [IW-1:0] s_idx;
	logic fifo_rdy, fifo_ov;
	logic [15:0] fifo_q, next_dq_out;
	logic [1:0] next_dq_oe;

	assign op = {cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n};
	assign sel = cke_q && !cmd_pins.cs_n;
	assign in_pd = dev == DV_PDN || dev == DV_APD || dev == DV_SELF_REFRESH_ENTRY_CMD;

	// Per-bank state, row and timers
	for (genvar b = 0; b < SRPD_BANKS; b++) begin : g_bank
		srpd_bank_t nst;
		logic [ROW_BITS-1:0] nrow;
		logic [3:0] tmr, ntmr;
		logic apf, napf;
		always_comb begin
			nst = bank_st[b];
			nrow = bank_row[b];
			ntmr = tmr;
			napf = apf;
			if (go_act[b]) begin
				nst = BK_ACT;
				nrow = addr[ROW_BITS-1:0];
			end else if (go_pre[b]) begin
				nst = BK_PRE;
				ntmr = SRPD_PRE_CYC;
			end else if (go_wrec[b]) begin
				nst = BK_WREC;
				ntmr = SRPD_WR_CYC;
				napf = c_ap;
			end else if (tmr != 4'h0) begin
				ntmr = tmr - 4'h1;
			end else if (bank_st[b] == BK_PRE) begin
				nst = BK_IDLE;
			end else if (bank_st[b] == BK_WREC) begin
				nst = apf ? BK_PRE : BK_ACT;
				ntmr = apf ? SRPD_PRE_CYC : 4'h0;
			end
		end
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				bank_st[b] <= BK_IDLE;
				bank_row[b] <= '0;
				tmr <= 4'h0;
				apf <= 1'b0;
			end else begin
				bank_st[b] <= nst;
				bank_row[b] <= nrow;
				tmr <= ntmr;
				apf <= napf;
			end
		end
	end

	// Burst length decode and column wrap mask
	always_comb begin
		case (bl)
			3'h0: len = 9'h001;
			3'h1: len = 9'h002;
			3'h2: len = 9'h004;
			3'h3: len = 9'h008;
			default: len = 9'h100;
		endcase
		full = bl == 3'h7;
		msk = full ? 8'hff : 8'(len - 9'h001);
	end

	// Command decode, legality and device state
	always_comb begin
		next_dev = dev;
		next_dev_tmr = dev_tmr;
		next_self_refresh_entry_cmd_tmr = self_refresh_entry_cmd_tmr;
		next_refresh_row = refresh_row;
		next_cl = cl;
		next_bl = bl;
		next_burst_on = burst_on;
		next_burst_wr = burst_wr;
		next_burst_ap = burst_ap;
		next_burst_bank = burst_bank;
		next_burst_col = burst_col;
		next_burst_left = burst_left;
		go_act = 2'h0;
		go_pre = 2'h0;
		go_wrec = 2'h0;
		step_rd = 1'b0;
		step_wr = 1'b0;
		illegal = 1'b0;
		ok = 1'b0;
		intr = 1'b0;
		start = 1'b0;
		can = 1'b0;
		c_col = burst_col;
		s_col = burst_col;
		c_left = burst_left;
		c_b = burst_bank;
		c_wr = burst_wr;
		c_ap = burst_ap;
		all_idle = !burst_on && bank_st[0] == BK_IDLE && bank_st[1] == BK_IDLE;
		quiet = !burst_on && bank_st[0] inside {BK_IDLE, BK_ACT}
			&& bank_st[1] inside {BK_IDLE, BK_ACT};
		case (dev)
			DV_RUN: begin
				if (sel) begin
					case (op)
						SRPD_OP_BST: illegal = (burst_on && burst_ap) || (!cke && quiet);
						SRPD_OP_RD, SRPD_OP_WR: illegal = bank_st[bank_sel] != BK_ACT
							|| (burst_on && burst_ap && burst_bank == bank_sel);
						SRPD_OP_ACT: illegal = bank_st[bank_sel] != BK_IDLE;
						SRPD_OP_PRE: illegal = addr[SRPD_AP_BIT]
							? (burst_on && burst_ap) || bank_st[0] == BK_WREC
								|| bank_st[1] == BK_WREC || (!cke && all_idle)
							: bank_st[bank_sel] inside {BK_WREC, BK_PRE}
								|| (burst_on && burst_ap && burst_bank == bank_sel);
						SRPD_OP_REF: illegal = !all_idle;
						SRPD_OP_MRS: illegal = !all_idle || bank_sel;
						default: illegal = 1'b0;
					endcase
				end
				ok = sel && !illegal;
				intr = ok && (op inside {SRPD_OP_BST, SRPD_OP_RD, SRPD_OP_WR}
					|| (op == SRPD_OP_PRE
						&& (addr[SRPD_AP_BIT] || bank_sel == burst_bank)));
				start = ok && op inside {SRPD_OP_RD, SRPD_OP_WR};
				if (burst_on && intr && burst_ap && !(op == SRPD_OP_PRE)) begin
					go_pre[burst_bank] = 1'b1;
				end
				if (intr) begin
					next_burst_on = 1'b0;
				end
				if (start) begin
					c_col = addr[7:0];
					c_left = len;
					c_b = bank_sel;
					c_wr = op == SRPD_OP_WR;
					c_ap = addr[SRPD_AP_BIT];
					next_burst_wr = c_wr;
					next_burst_ap = c_ap;
					next_burst_bank = c_b;
				end
				if (cke_q && (start || (burst_on && !intr))) begin
					can = c_wr || fifo_rdy;
					s_col = c_col;
					if (can) begin
						step_rd = !c_wr;
						step_wr = c_wr;
						c_col = (c_col & ~msk) | ((c_col + 8'h01) & msk);
						c_left = full ? c_left : c_left - 9'h001;
					end
					next_burst_col = c_col;
					next_burst_left = c_left;
					next_burst_on = full || c_left != 9'h000;
					if (!full && c_left == 9'h000) begin
						go_wrec[c_b] = c_wr;
						go_pre[c_b] = !c_wr && c_ap;
					end
				end
				if (ok) begin
					case (op)
						SRPD_OP_ACT: go_act[bank_sel] = 1'b1;
						SRPD_OP_PRE: begin
							for (int i = 0; i < SRPD_BANKS; i++) begin
								if (bank_st[i] == BK_ACT
									&& (addr[SRPD_AP_BIT] || bank_sel == 1'(i))) begin
									go_pre[i] = 1'b1;
								end
							end
						end
						SRPD_OP_REF: begin
							next_refresh_row = refresh_row + 1'b1;
							next_dev = cke ? DV_ARF : DV_SELF_REFRESH_ENTRY_CMD;
							next_dev_tmr = SRPD_RCA_CYC;
							// Timer counts 1..interval so each period is exact
							next_self_refresh_entry_cmd_tmr = 11'h001;
						end
						SRPD_OP_MRS: begin
							next_cl = addr[SRPD_CL_LSB+:3];
							next_bl = addr[SRPD_BL_LSB+:3];
							next_dev = cke ? DV_MRS : DV_PDN;
							next_dev_tmr = SRPD_MRD_CYC;
						end
						default: ;
					endcase
				end
				if (cke_q && !cke && quiet && (!sel || op == SRPD_OP_NOP)) begin
					next_dev = all_idle ? DV_PDN : DV_APD;
				end else if (ok && !cke && op == SRPD_OP_ACT && all_idle) begin
					next_dev = DV_APD;
				end
			end
			DV_ARF, DV_MRS: begin
				illegal = sel && op != SRPD_OP_NOP;
				next_dev_tmr = dev_tmr == 4'h0 ? 4'h0 : dev_tmr - 4'h1;
				next_dev = dev_tmr == 4'h0 ? DV_RUN : dev;
			end
			DV_SELF_REFRESH_ENTRY_CMD: begin
				next_self_refresh_entry_cmd_tmr = self_refresh_entry_cmd_tmr == SRPD_SELF_REFRESH_ENTRY_CMD_CYC ? 11'h001 : self_refresh_entry_cmd_tmr + 11'h001;
				if (self_refresh_entry_cmd_tmr == SRPD_SELF_REFRESH_ENTRY_CMD_CYC) begin
					next_refresh_row = refresh_row + 1'b1;
				end
				if (cke) begin
					next_dev = DV_ARF;
					next_dev_tmr = SRPD_RCA_CYC;
				end
			end
			default: next_dev = cke ? DV_RUN : dev;
		endcase
	end

	assign s_idx = {c_b, bank_row[c_b], s_col};
	assign pop = cke_q && dev == DV_RUN && (cl == SRPD_CL3 ? tok[2] : tok[1]);

	// Read words wait here for the latency pipe
	srpd_fifo #(.WIDTH(SRPD_DATA_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.in_valid(step_rd),
		.in_ready(fifo_rdy),
		.in_data(mem[s_idx]),
		.out_valid(fifo_ov),
		.out_ready(pop),
		.out_data(fifo_q)
	);

	// Output pins
	always_comb begin
		next_dq_out = dq_out;
		next_dq_oe = dq_oe;
		if (dev != DV_RUN) begin
			next_dq_oe = 2'h0;
		end else if (cke_q) begin
			// mask from previous edge, seen two edges on
			next_dq_oe = (pop && fifo_ov) ? ~dqm_d1 : 2'h0;
			next_dq_out = (pop && fifo_ov) ? fifo_q : dq_out;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (step_wr && !lower_byte_mask) begin
			mem[s_idx][7:0] <= dq_in[7:0];
		end
		if (step_wr && !upper_byte_mask) begin
			mem[s_idx][15:8] <= dq_in[15:8];
		end
	end

	// State registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cke_q <= 1'b0;
			dqm_d1 <= 2'h0;
			tok <= 2'h0;
			pd_d1 <= 1'b0;
			power_down_status <= 1'b0;
			dev <= DV_RUN;
			dev_tmr <= 4'h0;
			self_refresh_entry_cmd_tmr <= 11'h000;
			refresh_row <= '0;
			cl <= SRPD_CL_RESET;
			bl <= SRPD_BL_RESET;
			burst_on <= 1'b0;
			burst_wr <= 1'b0;
			burst_ap <= 1'b0;
			burst_bank <= 1'b0;
			burst_col <= 8'h00;
			burst_left <= 9'h000;
			dq_out <= 16'h0000;
			dq_oe <= 2'h0;
			protocol_violation <= 1'b0;
		end else begin
			cke_q <= cke;
			if (cke_q) begin
				dqm_d1 <= {upper_byte_mask, lower_byte_mask};
				tok <= {tok[1], step_rd};
			end
			pd_d1 <= in_pd;
			power_down_status <= pd_d1;
			dev <= next_dev;
			dev_tmr <= next_dev_tmr;
			self_refresh_entry_cmd_tmr <= next_self_refresh_entry_cmd_tmr;
			refresh_row <= next_refresh_row;
			cl <= next_cl;
			bl <= next_bl;
			burst_on <= next_burst_on;
			burst_wr <= next_burst_wr;
			burst_ap <= next_burst_ap;
			burst_bank <= next_burst_bank;
			burst_col <= next_burst_col;
			burst_left <= next_burst_left;
			dq_out <= next_dq_out;
			dq_oe <= next_dq_oe;
			protocol_violation <= illegal;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_pre_rd; ok && op == SRPD_OP_PRE && burst_on && !burst_wr && intr
		|=> !burst_on ##[1:3] dq_oe == 2'h0; endproperty
	a_pre_rd: assert property (p_pre_rd) else $error("read not ended");
	property p_pre_wr; ok && op == SRPD_OP_PRE && burst_on && burst_wr && intr
		|=> !burst_on && (start || !step_wr); endproperty
	a_pre_wr: assert property (p_pre_wr) else $error("write continued");
	property p_rmask; (cke_q && upper_byte_mask) ##1 pop
		|=> !dq_oe[1]; endproperty
	a_rmask: assert property (p_rmask) else $error("masked byte driven");
	property p_rmask_lo; (cke_q && lower_byte_mask) ##1 pop
		|=> !dq_oe[0]; endproperty
	a_rmask_lo: assert property (p_rmask_lo) else $error("masked low byte driven");
	property p_hold; !cke_q && dev == DV_RUN |=> $stable(dq_out); endproperty
	a_hold: assert property (p_hold) else $error("word changed");
	property p_pause; !cke_q |=> $stable(burst_col) && $stable(burst_left); endproperty
	a_pause: assert property (p_pause) else $error("burst moved");
	property p_ref; ok && op == SRPD_OP_REF |=> refresh_row == $past(refresh_row) + 1'b1;
	endproperty
	a_ref: assert property (p_ref) else $error("row counter stuck");
	property p_self_refresh_entry_cmd; dev == DV_SELF_REFRESH_ENTRY_CMD && !cke |=> dev == DV_SELF_REFRESH_ENTRY_CMD && dq_oe == 2'h0; endproperty
	a_self_refresh_entry_cmd: assert property (p_self_refresh_entry_cmd) else $error("self refresh left");
	property p_pd; dev == DV_RUN && cke_q && !cke && all_idle && !sel
		|-> ##3 power_down_status; endproperty
	a_pd: assert property (p_pd) else $error("status late");
	property p_ill; illegal && op == SRPD_OP_ACT |=> protocol_violation
		&& $stable(bank_row[0]) && $stable(bank_row[1]); endproperty
	a_ill: assert property (p_ill) else $error("illegal not flagged");
endmodule // srpd_core
`default_nettype wire

/* srpd_ctrl_model.sv */
// Behavioural memory controller that drives the command core's pins
`timescale 1ns/10ps
`default_nettype none
module srpd_ctrl_model
	import srpd_pkg::*;
(
	input wire logic ref_clk,
	output logic cke,
	output srpd_cmd_t cmd_pins,
	output logic [SRPD_ADDR_BITS-1:0] addr,
	output logic bank_sel,
	output logic upper_byte_mask,
	output logic lower_byte_mask,
	output logic [15:0] dq_in
);
	// Quiet pins at time zero, masks high so data stays off the bus
	initial begin
		cke = 1'b0;
		cmd_pins = 4'hf;
		addr = 11'h000;
		bank_sel = 1'b0;
		upper_byte_mask = 1'b1;
		lower_byte_mask = 1'b1;
		dq_in = 16'h0000;
	end
	// One command per falling edge; unused data lines toggle every cycle
	task automatic step(input logic [2:0] op, input logic bk, input logic [10:0] a,
		input logic [1:0] msk, input logic [15:0] d, input logic wr);
		@(negedge ref_clk);
		cmd_pins <= {op == SRPD_OP_NOP, op};
		bank_sel <= bk;
		addr <= a;
		{upper_byte_mask, lower_byte_mask} <= msk;
		dq_in <= wr ? d : ~dq_in;
	endtask
	// Deselected cycles
	task automatic nops(input int n);
		repeat (n) step(SRPD_OP_NOP, 1'b0, 11'h000, 2'b00, 16'h0000, 1'b0);
	endtask
	// gate changes only beside a command
	task automatic set_cke(input logic v);
		cke <= v;
	endtask
	// distributed refresh, then wait out the busy time
	task automatic refresh();
		step(SRPD_OP_REF, 1'b0, 11'h000, 2'b00, 16'h0000, 1'b0);
		nops(int'(SRPD_RCA_CYC) + 1);
	endtask
	// clock already running; only no-ops while waking
	task automatic wake();
		cke <= 1'b1;
		nops(int'(SRPD_RCA_CYC) + 2);
	endtask
endmodule // srpd_ctrl_model
`default_nettype wire

/* srpd_pkg.sv */
// Shared constants and types for the SDRAM command and power-down core
`default_nettype none
package srpd_pkg;
	localparam int SRPD_BANKS = 2;
	localparam int SRPD_ADDR_BITS = 11;
	localparam int SRPD_COL_BITS = 8;
	localparam int SRPD_DATA_BITS = 16;
	localparam int SRPD_CLK_MHZ = 100;
	// Timing figures in ns
	localparam int SRPD_PRECHARGE_TIME_NS = 20;
	localparam int SRPD_WRITE_RECOVERY_TIME_NS = 20;
	localparam int SRPD_REFRESH_CYCLE_TIME_NS = 70;
	localparam int SRPD_MODE_SET_DELAY_NS = 20;
	localparam int SRPD_REFRESH_PERIOD_NS = 15600;
	// Least times round up to whole cycles
	localparam logic [3:0] SRPD_PRE_CYC =
		4'((SRPD_PRECHARGE_TIME_NS * SRPD_CLK_MHZ + 999) / 1000);
	localparam logic [3:0] SRPD_WR_CYC =
		4'((SRPD_WRITE_RECOVERY_TIME_NS * SRPD_CLK_MHZ + 999) / 1000);
	localparam logic [3:0] SRPD_RCA_CYC =
		4'((SRPD_REFRESH_CYCLE_TIME_NS * SRPD_CLK_MHZ + 999) / 1000);
	localparam logic [3:0] SRPD_MRD_CYC =
		4'((SRPD_MODE_SET_DELAY_NS * SRPD_CLK_MHZ + 999) / 1000);
	// Self refresh interval rounds down
	localparam logic [10:0] SRPD_SELF_REFRESH_ENTRY_CMD_CYC =
		11'((SRPD_REFRESH_PERIOD_NS * SRPD_CLK_MHZ) / 1000);
	localparam int SRPD_REF_ROW_BITS = 12;
	// Mode word fields
	localparam int SRPD_AP_BIT = 10;
	localparam int SRPD_CL_LSB = 4;
	localparam int SRPD_BL_LSB = 0;
	localparam logic [2:0] SRPD_CL_RESET = 3'h2;
	localparam logic [2:0] SRPD_CL3 = 3'h3;
	localparam logic [2:0] SRPD_BL_RESET = 3'h0;
	// Opcodes as {ras_n, cas_n, we_n}
	localparam logic [2:0] SRPD_OP_NOP = 3'h7;
	localparam logic [2:0] SRPD_OP_BST = 3'h6;
	localparam logic [2:0] SRPD_OP_RD = 3'h5;
	localparam logic [2:0] SRPD_OP_WR = 3'h4;
	localparam logic [2:0] SRPD_OP_ACT = 3'h3;
	localparam logic [2:0] SRPD_OP_PRE = 3'h2;
	localparam logic [2:0] SRPD_OP_REF = 3'h1;
	localparam logic [2:0] SRPD_OP_MRS = 3'h0;
	// Command strobes from the controller
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} srpd_cmd_t;
	// Device-wide state
	typedef enum logic [2:0] {
		DV_RUN = 3'h0, DV_ARF = 3'h1, DV_MRS = 3'h3,
		DV_PDN = 3'h2, DV_APD = 3'h6, DV_SELF_REFRESH_ENTRY_CMD = 3'h7
	} srpd_dev_t;
	// Per-bank state
	typedef enum logic [1:0] {
		BK_IDLE = 2'h0, BK_ACT = 2'h1, BK_WREC = 2'h3, BK_PRE = 2'h2
	} srpd_bank_t;
endpackage
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the SDRAM command core
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import srpd_pkg::*;
;
	logic ref_clk;
	logic nrst;
	logic cke;
	srpd_cmd_t cmd_pins;
	logic [SRPD_ADDR_BITS-1:0] addr;
	logic bank_sel;
	logic upper_byte_mask;
	logic lower_byte_mask;
	logic [15:0] dq_in;
	logic [15:0] dq_out;
	logic [1:0] dq_oe;
	logic power_down_status;
	logic [SRPD_REF_ROW_BITS-1:0] refresh_row;
	logic protocol_violation;
	int miscompares;
	int total_checks;
	int seed;
	int n;
	logic bk;
	logic [10:0] row;
	logic [7:0] col;
	logic [15:0] a0, a1, b0, b1;
	logic [11:0] r0;
	// Clock, 10 ns period
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	srpd_core i_srpd_core (
		.ref_clk(ref_clk), .nrst(nrst), .cke(cke), .cmd_pins(cmd_pins), .addr(addr),
		.bank_sel(bank_sel), .upper_byte_mask(upper_byte_mask),
		.lower_byte_mask(lower_byte_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.power_down_status(power_down_status), .refresh_row(refresh_row),
		.protocol_violation(protocol_violation)
	);
	srpd_ctrl_model i_srpd_ctrl_model (
		.ref_clk(ref_clk), .cke(cke), .cmd_pins(cmd_pins), .addr(addr), .bank_sel(bank_sel),
		.upper_byte_mask(upper_byte_mask), .lower_byte_mask(lower_byte_mask), .dq_in(dq_in)
	);
	// Byte-masked write result
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] m);
		return {m[1] ? old[15:8] : nw[15:8], m[0] ? old[7:0] : nw[7:0]};
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic op(input logic [2:0] o, input logic b, input logic [10:0] a,
		input logic [1:0] m, input logic [15:0] d, input logic w);
		i_srpd_ctrl_model.step(o, b, a, m, d, w);
	endtask
	task automatic idle(input int k);
		i_srpd_ctrl_model.nops(k);
	endtask
	// Command, then look for the violation pulse over two cycles
	task automatic viol(input logic [2:0] o, input logic b, input logic [10:0] a, input logic e);
		logic s;
		op(o, b, a, 2'b00, 16'h0000, 1'b0);
		s = 1'b0;
		repeat (2) begin
			idle(1);
			s = s | protocol_violation;
		end
		check({15'h0, s}, {15'h0, e});
	endtask
	// Two-word write, optionally broken by a precharge on the second word
	task automatic wr2(input logic b, input logic [7:0] c, input logic [15:0] d0,
		input logic [15:0] d1, input logic [1:0] m0, input logic brk);
		op(SRPD_OP_WR, b, {3'h0, c}, m0, d0, 1'b1);
		op(brk ? SRPD_OP_PRE : SRPD_OP_NOP, b, 11'h000, 2'b00, d1, 1'b1);
		idle(4);
	endtask
	// Two-word read, low byte mask given with the command
	task automatic rd2(input logic b, input logic [7:0] c, input logic m, input logic [15:0] e0,
		input logic [15:0] e1, input logic ap);
		op(SRPD_OP_RD, b, {ap, 2'b00, c}, {1'b0, m}, 16'h0000, 1'b0);
		idle(2);
		check({14'h0, dq_oe}, {14'h0, 1'b1, ~m});
		check(dq_out & {8'hff, {8{~m}}}, e0 & {8'hff, {8{~m}}});
		idle(1);
		check(dq_out, e1);
		idle(1);
		check({14'h0, dq_oe}, 16'h0000);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Watchdog against a hung run
	initial begin
		#400000;
		miscompares++;
		end_sim();
	end
	// Main sequence
	initial begin
		miscompares = 0;
		total_checks = 0;
		nrst = 1'b0;
		seed = $urandom(32'hb65c8837);
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst <= 1'b1;
		i_srpd_ctrl_model.set_cke(1'b1);
		idle(2);
		op(SRPD_OP_MRS, 1'b0, 11'h021, 2'b00, 16'h0000, 1'b0);
		idle(3);
		bk = 1'($urandom % 2);
		row = 11'($urandom);
		col = {7'($urandom), 1'b0};
		a0 = 16'($urandom);
		a1 = 16'($urandom);
		b0 = 16'($urandom);
		b1 = 16'($urandom);
		// Unmasked write, upper-masked precharge-broken write, unmasked and low-masked reads
		op(SRPD_OP_ACT, bk, row, 2'b00, 16'h0000, 1'b0);
		idle(2);
		viol(SRPD_OP_ACT, bk, row, 1'b1);
		wr2(bk, col, a0, a1, 2'b00, 1'b0);
		wr2(bk, col, b0, b1, 2'b10, 1'b1);
		op(SRPD_OP_ACT, bk, row, 2'b00, 16'h0000, 1'b0);
		idle(2);
		rd2(bk, col, 1'b0, merge(a0, b0, 2'b10), a1, 1'b0);
		rd2(bk, col, 1'b1, merge(a0, b0, 2'b10), a1, 1'b1);
		idle(2);
		viol(SRPD_OP_RD, bk, 11'h000, 1'b1);
		viol(SRPD_OP_BST, bk, 11'h000, 1'b0);
		// Eight-word read at latency three, cut short by precharge-all
		op(SRPD_OP_MRS, 1'b0, 11'h033, 2'b00, 16'h0000, 1'b0);
		idle(3);
		op(SRPD_OP_ACT, bk, row, 2'b00, 16'h0000, 1'b0);
		idle(2);
		op(SRPD_OP_RD, bk, {3'h0, col}, 2'b00, 16'h0000, 1'b0);
		idle(1);
		op(SRPD_OP_PRE, bk, 11'h400, 2'b00, 16'h0000, 1'b0);
		idle(2);
		check({14'h0, dq_oe}, 16'h0003);
		idle(1);
		check({14'h0, dq_oe}, 16'h0000);
		idle(1);
		viol(SRPD_OP_RD, bk, 11'h000, 1'b1);
		// Clock suspend stretches the burst by two cycles
		op(SRPD_OP_ACT, bk, row, 2'b00, 16'h0000, 1'b0);
		idle(2);
		op(SRPD_OP_RD, bk, {3'h0, col}, 2'b00, 16'h0000, 1'b0);
		n = 0;
		for (int i = 0; i < 20; i++) begin
			idle(1);
			if (i == 2) i_srpd_ctrl_model.set_cke(1'b0);
			if (i == 4) i_srpd_ctrl_model.set_cke(1'b1);
			if (dq_oe !== 2'b00) n++;
		end
		check(16'(n), 16'd10);
		op(SRPD_OP_PRE, bk, 11'h400, 2'b00, 16'h0000, 1'b0);
		idle(3);
		// Idle power down, then active power down
		for (int k = 0; k < 2; k++) begin
			if (k == 1) begin
				op(SRPD_OP_ACT, bk, row, 2'b00, 16'h0000, 1'b0);
				idle(2);
			end
			idle(1);
			i_srpd_ctrl_model.set_cke(1'b0);
			idle(1);
			check({15'h0, power_down_status}, 16'h0000);
			idle(2);
			check({15'h0, power_down_status}, 16'h0001);
			op(SRPD_OP_RD, bk, {3'h0, col}, 2'b00, 16'h0000, 1'b0);
			idle(3);
			check({13'h0, dq_oe, protocol_violation}, 16'h0000);
			i_srpd_ctrl_model.wake();
			check({15'h0, power_down_status}, 16'h0000);
			if (k == 1) begin
				op(SRPD_OP_RD, bk, {3'h0, col}, 2'b00, 16'h0000, 1'b0);
				idle(3);
				check({14'h0, dq_oe}, 16'h0003);
				op(SRPD_OP_PRE, bk, 11'h400, 2'b00, 16'h0000, 1'b0);
				idle(3);
			end
		end
		// Auto refresh steps the internal row counter
		r0 = refresh_row;
		n = 1 + int'($urandom % 4);
		repeat (n) i_srpd_ctrl_model.refresh();
		check(16'(refresh_row), 16'(r0 + 12'(n)));
		// only an idle bank is opened here
		op(SRPD_OP_ACT, ~bk, row, 2'b00, 16'h0000, 1'b0);
		idle(2);
		viol(SRPD_OP_REF, 1'b0, 11'h000, 1'b1);
		check(16'(refresh_row), 16'(r0 + 12'(n)));
		op(SRPD_OP_PRE, ~bk, 11'h400, 2'b00, 16'h0000, 1'b0);
		idle(3);
		// Self refresh runs from its own timer
		r0 = refresh_row;
		op(SRPD_OP_REF, 1'b0, 11'h000, 2'b00, 16'h0000, 1'b0);
		i_srpd_ctrl_model.set_cke(1'b0);
		idle(2 * int'(SRPD_SELF_REFRESH_ENTRY_CMD_CYC) + 20);
		// Entry command refreshes one row, the timer two more
		check({1'b0, refresh_row, dq_oe, power_down_status}, {1'b0, r0 + 12'h003, 3'h1});
		i_srpd_ctrl_model.wake();
		check({15'h0, power_down_status}, 16'h0000);
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
